// File: core/cfl_pkg.sv
// Shared constants and types of the start-up configuration loader.
package cfl_pkg;
	// -------------------------------------------------------------
	// Character codes seen in the configuration text.
	// -------------------------------------------------------------
	localparam logic [7:0] CH_LF    = 8'h0A; // Line end.
	localparam logic [7:0] CH_CR    = 8'h0D; // Ignored everywhere.
	localparam logic [7:0] CH_SEMI  = 8'h3B; // Comment start.
	localparam logic [7:0] CH_HASH  = 8'h23; // Conditional start.
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_EQ    = 8'h3D;
	localparam logic [7:0] CH_DOT   = 8'h2E;
	localparam logic [7:0] CH_OR    = 8'h7C;
	localparam logic [7:0] CH_AND   = 8'h26;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_ONE   = 8'h31;
	localparam logic [7:0] CH_FOUR  = 8'h34;
	localparam logic [7:0] CH_XLO   = 8'h78;
	localparam logic [7:0] CH_XUP   = 8'h58;
	// -------------------------------------------------------------
	// Field widths and digit counts.
	// -------------------------------------------------------------
	localparam logic [2:0] IDX_DIGITS = 3'h4; // Index hex digits.
	localparam logic [2:0] SUB_DIGITS = 3'h2; // Subindex hex digits.
	localparam logic [8:0] BIT_LIMIT  = 9'h020; // Bit positions 0..31.
	localparam int         SW_COUNT   = 4;
	// -------------------------------------------------------------
	// Storage commands issued by the start-up sequencer.
	// -------------------------------------------------------------
	localparam logic [1:0] FS_PURGE  = 2'h0; // Drop all but kept files.
	localparam logic [1:0] FS_CREATE = 2'h1; // Make empty config file.
	localparam logic [1:0] FS_DELRST = 2'h2; // Drop restart-request file.
	localparam logic [1:0] FS_READ   = 2'h3; // Stream config file.
	// -------------------------------------------------------------
	// Whole-word constants: zero for resets, ones for full masks.
	// -------------------------------------------------------------
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;
	// Start-up sequence states.
	typedef enum logic [2:0] {
		B_IDLE, B_PURGE, B_CHECK, B_CREATE, B_DELRST, B_READ, B_SWITCH, B_RUN
	} cfl_boot_e;
	// Line parser states.
	typedef enum logic [3:0] {
		P_START, P_COND, P_CCOL, P_IDX, P_SUB, P_BIT, P_BITV, P_OPCH,
		P_VAL0, P_VALX, P_HEX, P_DEC, P_END, P_SKIP
	} cfl_parse_e;
	// Kind of object write.
	typedef enum logic [1:0] {OP_SET, OP_OR, OP_AND, OP_BIT} cfl_op_e;
endpackage : cfl_pkg

// File: core/cfl_loader.sv
// Start-up configuration loader: boot sequence and line interpreter.
`timescale 1ns/1ps
// How it works
// RULE1: File first, then switches, then program.
// RULE2: Lines run in order, first to last.
// RULE3: Semicolon line is a comment, skipped.
// RULE4: Index is exactly four hex digits.
// RULE5: Subindex two hex digits, or omitted.
// RULE6: Value with 0x prefix is hexadecimal.
// RULE7: Bit set/clear, OR and AND supported.
// RULE8: Spaces around equals make line invalid.
// RULE9: Leading spaces make line invalid.
// RULE10: Values written without any checking.
// RULE11: Hash-switch line runs only if switch on.
// RULE12: Switch number must be 1 to 4.
// RULE13: Later write to same object wins.
// RULE14: Power-up purges all but kept files.
// RULE15: Missing config file gets created empty.
// RULE16: Restart-request file restarts, deleted next boot.
// RULE17: Config save stops motor, applies at restart.
// RULE18: Storage exposes config, program, info files.
// RULE19: Unprefixed value and bit number decimal.
// RULE20: Malformed line writes nothing, parsing continues.
module cfl_loader
	import cfl_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          nrst,
	input  wire logic [3:0]    mode_select_switch, // Switch pins, 1 = on.
	output logic               fs_req_r,           // Storage command request.
	output logic [1:0]         fs_op_r,            // Storage command code.
	input  wire logic          fs_done,            // Command finished pulse.
	input  wire logic          cfg_missing,        // Config file absent.
	input  wire logic          byte_valid,         // Config text byte valid.
	input  wire logic [7:0]    byte_data,
	input  wire logic          byte_last,          // Last byte of the file.
	output logic               byte_ready_r,
	output logic               od_wr_r,            // Object write pulse.
	output logic [15:0]        od_index_r,
	output logic [7:0]         od_sub_r,
	output logic [31:0]        od_mask_r,          // Bits to replace.
	output logic [31:0]        od_data_r,          // New bit values.
	output logic [3:0]         mode_sw_r,          // Switches taken as config.
	output logic               mode_valid_r,
	output logic               prog_run_r,         // User program start.
	input  wire logic          reset_file_written, // Host wrote restart file.
	output logic               restart_req_r,
	input  wire logic          host_cfg_saved,     // Host saved config file.
	output logic               motor_stop_r
);
	// ---------------------------------------------------------------
	// Character helpers.
	// ---------------------------------------------------------------
	// True for 0-9, A-F and a-f.
	function automatic logic is_hex(input logic [7:0] c);
		return (c inside {[8'h30:8'h39], [8'h41:8'h46], [8'h61:8'h66]});
	endfunction : is_hex
	// Nibble value of a hex character.
	function automatic logic [3:0] hex_val(input logic [7:0] c);
		if (c <= 8'h39) begin
			return c[3:0];
		end
		return 4'(c[3:0] + 4'h9);
	endfunction : hex_val
	// True for a decimal digit.
	function automatic logic is_dec(input logic [7:0] c);
		return (c inside {[8'h30:8'h39]});
	endfunction : is_dec

	// ---------------------------------------------------------------
	// Switch synchroniser and state.
	// ---------------------------------------------------------------
	logic [3:0]  sw_m_r, sw_s_r;  // Two-stage pin synchroniser.
	cfl_boot_e   boot_r, boot_nxt;
	cfl_parse_e  p_r, p_nxt;
	cfl_op_e     op_r, op_nxt;
	logic [15:0] idx_r, idx_nxt;
	logic [7:0]  sub_r, sub_nxt;
	logic [8:0]  bit_r, bit_nxt;   // Wide enough for one more digit.
	logic        bv_r, bv_nxt;     // Bit value of a single-bit write.
	logic [31:0] val_r, val_nxt;
	logic [2:0]  cnt_r, cnt_nxt;   // Digits seen in current field.
	logic        cond_r, cond_nxt; // Line is switch-conditional.
	logic [1:0]  sel_r, sel_nxt;   // Switch chosen by the line.
	logic        done_read_r;      // Helper: file read has ended.

	wire       take   = byte_valid && byte_ready_r;
	wire [7:0] ch     = byte_data;
	wire       ch_lf  = (ch == CH_LF);
	wire [3:0] nib    = hex_val(ch);
	wire [8:0] bit_dg = 9'(bit_r * 9'd10 + 9'(ch[3:0]));
	// The value after this character, before a line end hits.
	cfl_parse_e pv;
	assign pv = ch_lf ? p_r : p_nxt;
	wire val_ok  = (pv inside {P_VALX, P_DEC, P_END}) || (pv == P_HEX && cnt_nxt != 3'h0);
	wire term    = take && (ch_lf || byte_last);
	wire sw_on   = sw_s_r[sel_nxt];
	wire commit  = term && val_ok && (!cond_nxt || sw_on); // see RULE11
	wire last_in = take && byte_last;
	wire read_end = (boot_r == B_READ) && (last_in || fs_done);

	// ---------------------------------------------------------------
	// Start-up sequencer.
	// ---------------------------------------------------------------
	// Purge, create if missing, drop restart file, read, then switches.
	always_comb begin
		boot_nxt = boot_r;
		unique case (boot_r)
			B_IDLE:   boot_nxt = B_PURGE;
			B_PURGE:  if (fs_done) begin // see RULE14 and RULE18
				boot_nxt = B_CHECK;
			end
			B_CHECK:  boot_nxt = cfg_missing ? B_CREATE : B_DELRST; // see RULE15
			B_CREATE: if (fs_done) begin
				boot_nxt = B_DELRST;
			end
			B_DELRST: if (fs_done) begin // see RULE16
				boot_nxt = B_READ;
			end
			B_READ:   if (read_end) begin // see RULE1
				boot_nxt = B_SWITCH;
			end
			B_SWITCH: boot_nxt = B_RUN;
			B_RUN:    boot_nxt = B_RUN;
		endcase
	end

	// Storage command code follows the next boot state.
	wire [1:0] op_of = (boot_nxt == B_PURGE)  ? FS_PURGE :
	                   (boot_nxt == B_CREATE) ? FS_CREATE :
	                   (boot_nxt == B_DELRST) ? FS_DELRST : FS_READ;
	wire req_of = boot_nxt inside {B_PURGE, B_CREATE, B_DELRST, B_READ};

	// Sequencer registers; outputs are registered from next state.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			boot_r       <= B_IDLE;
			fs_req_r     <= 1'b0;
			fs_op_r      <= FS_PURGE;
			byte_ready_r <= 1'b0;
			done_read_r  <= 1'b0;
		end else begin
			boot_r       <= boot_nxt;
			fs_req_r     <= req_of;
			fs_op_r      <= op_of;
			byte_ready_r <= (boot_nxt == B_READ);
			done_read_r  <= done_read_r || read_end;
		end
	end

	// Switches are sampled once after the file, then program starts.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sw_m_r       <= 4'h0;
			sw_s_r       <= 4'h0;
			mode_sw_r    <= 4'h0;
			mode_valid_r <= 1'b0;
			prog_run_r   <= 1'b0;
		end else begin
			sw_m_r <= mode_select_switch;
			sw_s_r <= sw_m_r;
			if (boot_r == B_SWITCH) begin // see RULE1
				mode_sw_r    <= sw_s_r;
				mode_valid_r <= 1'b1;
			end
			prog_run_r <= prog_run_r || (boot_r == B_RUN);
		end
	end

	// ---------------------------------------------------------------
	// Line parser. Spaces, stray characters and bad digit counts
	// drop to P_SKIP, which waits for the line end (see RULE20).
	// ---------------------------------------------------------------
	always_comb begin
		p_nxt = P_SKIP;
		op_nxt = op_r;
		idx_nxt = idx_r;
		sub_nxt = sub_r;
		bit_nxt = bit_r;
		bv_nxt = bv_r;
		val_nxt = val_r;
		cnt_nxt = cnt_r;
		cond_nxt = cond_r;
		sel_nxt = sel_r;
		if (!take || ch == CH_CR) begin
			p_nxt = p_r;
		end else if (ch_lf) begin
			p_nxt = P_START; // see RULE2
		end else begin
			unique case (p_r)
				P_START: begin
					cond_nxt = 1'b0;
					cnt_nxt = 3'h1;
					idx_nxt = {12'h000, nib};
					sub_nxt = 8'h00;
					bit_nxt = 9'h000;
					if (ch == CH_SEMI) begin // see RULE3
						p_nxt = P_SKIP;
					end else if (ch == CH_HASH) begin
						p_nxt = P_COND;
					end else if (is_hex(ch)) begin // see RULE9
						p_nxt = P_IDX;
					end
				end
				P_COND: if (ch >= CH_ONE && ch <= CH_FOUR) begin // see RULE12
					sel_nxt = 2'(ch[2:0] - 3'h1);
					cond_nxt = 1'b1;
					p_nxt = P_CCOL;
				end
				P_CCOL: if (ch == CH_COLON) begin
					cnt_nxt = 3'h0;
					p_nxt = P_IDX;
				end
				P_IDX: begin
					if (is_hex(ch) && cnt_r < IDX_DIGITS) begin // see RULE4
						idx_nxt = {idx_r[11:0], nib};
						cnt_nxt = 3'(cnt_r + 3'h1);
						p_nxt = P_IDX;
					end else if (ch == CH_COLON && cnt_r == IDX_DIGITS) begin
						cnt_nxt = 3'h0;
						p_nxt = P_SUB;
					end
				end
				P_SUB: begin
					if (is_hex(ch) && cnt_r < SUB_DIGITS) begin // see RULE5
						sub_nxt = {sub_r[3:0], nib};
						cnt_nxt = 3'(cnt_r + 3'h1);
						p_nxt = P_SUB;
					end else if (cnt_r != 3'h1) begin
						// An omitted subindex keeps the value zero.
						if (ch == CH_EQ) begin // see RULE8
							op_nxt = OP_SET;
							p_nxt = P_VAL0;
						end else if (ch == CH_OR) begin // see RULE7
							op_nxt = OP_OR;
							p_nxt = P_OPCH;
						end else if (ch == CH_AND) begin
							op_nxt = OP_AND;
							p_nxt = P_OPCH;
						end else if (ch == CH_DOT) begin
							op_nxt = OP_BIT;
							p_nxt = P_BIT;
						end
					end
				end
				P_BIT: begin
					if (is_dec(ch) && bit_dg < BIT_LIMIT) begin // see RULE19
						bit_nxt = bit_dg;
						p_nxt = P_BIT;
					end else if (ch == CH_EQ) begin
						p_nxt = P_BITV;
					end
				end
				P_BITV: if (ch == CH_ZERO || ch == CH_ONE) begin // see RULE7
					bv_nxt = ch[0];
					p_nxt = P_END;
				end
				P_OPCH: if (ch == CH_EQ) begin
					p_nxt = P_VAL0;
				end
				P_VAL0: if (is_dec(ch)) begin
					val_nxt = {28'h0000000, ch[3:0]};
					p_nxt = (ch == CH_ZERO) ? P_VALX : P_DEC;
				end
				P_VALX: begin
					cnt_nxt = 3'h0;
					if (ch == CH_XLO || ch == CH_XUP) begin // see RULE6
						p_nxt = P_HEX;
					end else if (is_dec(ch)) begin
						val_nxt = {28'h0000000, ch[3:0]};
						p_nxt = P_DEC;
					end
				end
				P_HEX: if (is_hex(ch)) begin
					val_nxt = {val_r[27:0], nib};
					cnt_nxt = 3'h1;
					p_nxt = P_HEX;
				end
				P_DEC: if (is_dec(ch)) begin // see RULE19
					val_nxt = 32'((val_r << 3) + (val_r << 1) + 32'(ch[3:0]));
					p_nxt = P_DEC;
				end
				P_END, P_SKIP: p_nxt = P_SKIP;
			endcase
		end
	end

	// Parser registers.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			p_r <= P_START;
			op_r <= OP_SET;
			idx_r <= 16'h0000;
			sub_r <= 8'h00;
			bit_r <= 9'h000;
			bv_r <= 1'b0;
			val_r <= WORD_ZERO;
			cnt_r <= 3'h0;
			cond_r <= 1'b0;
			sel_r <= 2'h0;
		end else begin
			p_r <= p_nxt;
			op_r <= op_nxt;
			idx_r <= idx_nxt;
			sub_r <= sub_nxt;
			bit_r <= bit_nxt;
			bv_r <= bv_nxt;
			val_r <= val_nxt;
			cnt_r <= cnt_nxt;
			cond_r <= cond_nxt;
			sel_r <= sel_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Object write as a masked store: new = old & ~mask | data & mask.
	// ---------------------------------------------------------------
	// One shift serves the single-bit forms.
	wire [31:0] bit_m  = 32'h0000_0001 << bit_nxt[4:0];
	wire [31:0] mask_w = (op_nxt == OP_OR)  ? val_nxt :
	                     (op_nxt == OP_AND) ? ~val_nxt :
	                     (op_nxt == OP_BIT) ? bit_m : WORD_ONES;
	wire [31:0] data_w = (op_nxt == OP_SET) ? val_nxt :
	                     (op_nxt == OP_BIT && !bv_nxt) ? WORD_ZERO :
	                     (op_nxt == OP_AND) ? WORD_ZERO : WORD_ONES;

	// No range or type check: the text author owns the values.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			od_wr_r <= 1'b0;
			od_index_r <= 16'h0000;
			od_sub_r <= 8'h00;
			od_mask_r <= WORD_ZERO;
			od_data_r <= WORD_ZERO;
		end else begin
			od_wr_r <= commit; // see RULE13
			if (commit) begin // see RULE10
				od_index_r <= idx_nxt;
				od_sub_r <= sub_nxt;
				od_mask_r <= mask_w;
				od_data_r <= data_w;
			end
		end
	end

	// ---------------------------------------------------------------
	// Host events: restart request and config save.
	// ---------------------------------------------------------------
	// Both are sticky until the device is reset by the restart.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			restart_req_r <= 1'b0;
			motor_stop_r <= 1'b0;
		end else begin
			restart_req_r <= restart_req_r || reset_file_written; // see RULE16
			motor_stop_r <= motor_stop_r || host_cfg_saved; // see RULE17
		end
	end

	// ---------------------------------------------------------------
	// Checks.
	// ---------------------------------------------------------------
	prog_after_sw_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE1
		$rose(prog_run_r) |-> mode_valid_r && done_read_r)
		else $error("program started before file and switches");
	sw_after_file_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE1
		$rose(mode_valid_r) |-> $past(done_read_r) && !byte_ready_r)
		else $error("switches taken before file end");
	comment_skip_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE3
		take && p_r == P_START && ch == CH_SEMI && !byte_last |=> p_r == P_SKIP ##0 !od_wr_r)
		else $error("comment line not skipped");
	skip_nowrite_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE20
		take && p_r == P_SKIP |=> !od_wr_r)
		else $error("malformed line wrote an object");
	cond_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE11
		term && cond_nxt && !sw_s_r[sel_nxt] |=> !od_wr_r)
		else $error("conditional write with switch off");
	bit_onehot_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE7
		od_wr_r && op_r == OP_BIT |-> $onehot(od_mask_r))
		else $error("single-bit write touches several bits");
	purge_first_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE14
		$rose(fs_req_r) && $past(boot_r) == B_IDLE |-> fs_op_r == FS_PURGE)
		else $error("first storage command is not purge");
	create_miss_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE15
		boot_r == B_CHECK && cfg_missing |=> fs_req_r && fs_op_r == FS_CREATE)
		else $error("missing config file not created");
	restart_req_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE16
		reset_file_written |=> restart_req_r)
		else $error("restart file did not request restart");
	motor_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see RULE17
		host_cfg_saved |=> motor_stop_r [*2])
		else $error("config save did not stop motor");
endmodule : cfl_loader

// File: verification/cfl_store_model.sv
// Storage-side model: answers storage commands and streams the configuration text.
`timescale 1ns/1ps
module cfl_store_model
	import cfl_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       fs_req_r,
	input  wire logic [1:0] fs_op_r,
	input  wire logic       byte_ready_r,
	output logic            fs_done,
	output logic            byte_valid,
	output logic [7:0]      byte_data,
	output logic            byte_last
);
	// -------------------------------------------------------------
	// Content set by the bench, and the log of commands seen.
	// -------------------------------------------------------------
	string      text;    // File content, kept across resets.
	bit         slow;    // Adds random stalls to every answer but the empty-file end.
	int         pos;     // Next byte to send.
	logic [7:0] ops_log; // Commands seen, newest in the low bits.
	int         ops_n;   // Number of commands seen.
	logic       req_q;   // Request as seen one edge ago.
	logic [1:0] op_q;    // Command code as seen one edge ago.
	logic       served;  // The current command has been answered.
	wire        rd;      // The loader asks for the file text.
	assign rd = fs_req_r && fs_op_r == FS_READ;
	// -------------------------------------------------------------
	// Answers; a stall only delays, it never drops a request.
	// -------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fs_done <= 1'b0;
			byte_valid <= 1'b0;
			byte_last <= 1'b0;
			byte_data <= 8'h00;
			req_q <= 1'b0;
			op_q <= 2'h0;
			served <= 1'b0;
			ops_log <= 8'h00;
			ops_n <= 0;
			pos = 0;
		end else begin
			fs_done <= 1'b0;
			req_q <= fs_req_r;
			op_q <= fs_op_r;
			// A new command is logged once, whatever its length.
			if (fs_req_r && (!req_q || fs_op_r != op_q)) begin
				ops_log <= {ops_log[5:0], fs_op_r};
				ops_n <= ops_n + 1;
				served <= 1'b0;
			end
			// Purge, create and delete finish, after a random stall when slow is set.
			if (fs_req_r && !rd && !served && (!slow || $urandom % 3 == 0)) begin
				fs_done <= 1'b1;
				served <= 1'b1;
			end
			// An empty file is reported as ended at once.
			if (rd && !served && text.len() == 0) begin
				fs_done <= 1'b1;
				served <= 1'b1;
			end
			// A taken byte is withdrawn; the line shows junk, not the old byte.
			if (byte_valid && byte_ready_r) begin
				byte_valid <= 1'b0;
				byte_last <= 1'b0;
				byte_data <= ~byte_data;
			end
			// Bytes go out strictly in file order.
			if (rd && byte_ready_r && pos < text.len() && (!slow || $urandom % 2 == 0)) begin
				byte_valid <= 1'b1;
				byte_data <= text[pos];
				byte_last <= (pos == text.len() - 1);
				pos = pos + 1;
			end
		end
	end
endmodule : cfl_store_model

// File: verification/test_cfl_loader.sv
// Self-checking bench of the start-up configuration loader.
`timescale 1ns/1ps
module test_cfl_loader
	import cfl_pkg::*;
;
	// -------------------------------------------------------------
	// Signals, counters and expectation queues.
	// -------------------------------------------------------------
	logic        ref_clk = 1'b0;
	logic        nrst, cfg_missing, reset_file_written, host_cfg_saved;
	logic [3:0]  mode_select_switch;
	logic        fs_done, byte_valid, byte_last, fs_req_r, byte_ready_r, od_wr_r;
	logic [7:0]  byte_data, od_sub_r;
	logic [1:0]  fs_op_r;
	logic [15:0] od_index_r;
	logic [31:0] od_mask_r, od_data_r;
	logic [3:0]  mode_sw_r;
	logic        mode_valid_r, prog_run_r, restart_req_r, motor_stop_r;
	int          num_errors = 0;
	int          samples_checked = 0;
	string       txt;               // File text being built.
	logic [87:0] exp_q[$], got_q[$]; // {index, sub, mask, data & mask}.
	logic [3:0]  sw;
	always #50 ref_clk = ~ref_clk;
	cfl_loader dut (.ref_clk(ref_clk), .nrst(nrst), .mode_select_switch(mode_select_switch), .fs_req_r(fs_req_r),
		.fs_op_r(fs_op_r), .fs_done(fs_done), .cfg_missing(cfg_missing), .byte_valid(byte_valid),
		.byte_data(byte_data), .byte_last(byte_last), .byte_ready_r(byte_ready_r), .od_wr_r(od_wr_r),
		.od_index_r(od_index_r), .od_sub_r(od_sub_r), .od_mask_r(od_mask_r), .od_data_r(od_data_r),
		.mode_sw_r(mode_sw_r), .mode_valid_r(mode_valid_r), .prog_run_r(prog_run_r),
		.reset_file_written(reset_file_written), .restart_req_r(restart_req_r),
		.host_cfg_saved(host_cfg_saved), .motor_stop_r(motor_stop_r));
	cfl_store_model store (.ref_clk(ref_clk), .nrst(nrst), .fs_req_r(fs_req_r), .fs_op_r(fs_op_r),
		.byte_ready_r(byte_ready_r), .fs_done(fs_done), .byte_valid(byte_valid), .byte_data(byte_data),
		.byte_last(byte_last));
	// -------------------------------------------------------------
	// Helpers.
	// -------------------------------------------------------------
	task automatic check(input bit ok, input string msg);
		samples_checked++;
		if (!ok) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic tally_and_finish;
		if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	function automatic string hx(input logic [31:0] v, input int w);
		string s;
		s = (w == 4) ? $sformatf("%04h", v[15:0]) : (w == 2) ? $sformatf("%02h", v[7:0]) : $sformatf("%0h", v);
		return s.toupper();
	endfunction : hx
	// Appends one line and, if it must write, the write it must give.
	task automatic ln(input string s, input bit w = 0, input logic [15:0] i = 16'h0000, input logic [7:0] b = 8'h00,
		input logic [31:0] m = 32'h0000_0000, input logic [31:0] dm = 32'h0000_0000, input string e = "\n");
		txt = {txt, s, e};
		if (w) exp_q.push_back({i, b, m, dm});
	endtask : ln
	// One random line of one of six accepted forms.
	task automatic rnd_line;
		logic [15:0] i;
		logic [7:0]  b;
		logic [31:0] v;
		int          k, n, s;
		string       h;
		i = $urandom;
		b = $urandom;
		v = $urandom;
		k = $urandom % 6;
		n = $urandom % 32;
		s = 1 + $urandom % 4;
		h = {hx(i, 4), ":", hx(b, 2)};
		case (k)
			0: ln({h, "=", $sformatf("%0d", v)}, 1, i, b, WORD_ONES, v);
			1: ln({h, "=0x", hx(v, 0)}, 1, i, b, WORD_ONES, v);
			2: ln({h, "|=0x", hx(v, 0)}, 1, i, b, v, v);
			3: ln({h, "&=0x", hx(v, 0)}, 1, i, b, ~v, WORD_ZERO);
			4: ln({h, ".", $sformatf("%02d=%0d", n, v[0])}, 1, i, b, 32'h1 << n, v[0] ? 32'h1 << n : 32'h0);
			default: ln({$sformatf("#%0d:", s), h, "=", $sformatf("%0d", v)}, sw[s-1], i, b, WORD_ONES, v);
		endcase
	endtask : rnd_line
	// Boots once with the built text and compares everything seen.
	task automatic boot(input bit miss, input bit slow);
		int n;
		store.text = txt;
		store.slow = slow;
		got_q.delete();
		mode_select_switch <= sw;
		cfg_missing <= miss;
		nrst <= 1'b0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		n = 0;
		while (prog_run_r !== 1'b1 && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20000) begin
			check(0, "boot did not finish");
			tally_and_finish();
		end
		check(store.ops_n == (miss ? 4 : 3), "command count");
		check(store.ops_log[5:0] === (miss ? 6'h1B : 6'h0B), "command order");
		check(got_q.size() == exp_q.size(), $sformatf("got %0d writes", got_q.size()));
		foreach (exp_q[j]) if (j < got_q.size()) check(got_q[j] === exp_q[j], $sformatf("write %0d", j));
		check(mode_sw_r === sw && mode_valid_r === 1'b1, "switch snapshot");
		check(restart_req_r === 1'b0 && motor_stop_r === 1'b0, "event outputs raised early");
		host_cfg_saved <= 1'b1;
		reset_file_written <= 1'b1;
		@(posedge ref_clk);
		host_cfg_saved <= 1'b0;
		reset_file_written <= 1'b0;
		@(posedge ref_clk);
		#1;
		check(motor_stop_r === 1'b1, "motor not stopped");
		check(restart_req_r === 1'b1, "no restart request");
	endtask : boot
	// -------------------------------------------------------------
	// Monitor: collects writes and watches the start-up order.
	// -------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (od_wr_r === 1'b1) got_q.push_back({od_index_r, od_sub_r, od_mask_r, od_data_r & od_mask_r});
		if (nrst && prog_run_r === 1'b1 && mode_valid_r !== 1'b1) check(0, "program before switches");
		if (mode_valid_r === 1'b1 && (od_wr_r === 1'b1 || byte_ready_r === 1'b1)) check(0, "file late");
	end
	// -------------------------------------------------------------
	// Main sequence: corner file, random file, empty file.
	// -------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		cfg_missing = 1'b0;
		reset_file_written = 1'b0;
		host_cfg_saved = 1'b0;
		mode_select_switch = 4'h0;
		void'($urandom(74));
		// Hand-written corner lines; switch 2 on, the others off.
		sw = 4'h2;
		txt = "";
		ln("; 1234:00=5");
		ln("203B:01=600", 1, 16'h203B, 8'h01, WORD_ONES, 32'd600);
		ln("3202:00=0x1F", 1, 16'h3202, 8'h00, WORD_ONES, 32'h0000_001F);
		ln("2300:=1", 1, 16'h2300, 8'h00, WORD_ONES, 32'h0000_0001);
		ln("3202:00.03=1", 1, 16'h3202, 8'h00, 32'h0000_0008, 32'h0000_0008);
		ln("3202:00.31=0", 1, 16'h3202, 8'h00, 32'h8000_0000, WORD_ZERO);
		ln("3202:00|=0x08", 1, 16'h3202, 8'h00, 32'h0000_0008, 32'h0000_0008);
		ln("3202:00&=0x08", 1, 16'h3202, 8'h00, 32'hFFFF_FFF7, WORD_ZERO);
		ln("#2:2057:00=2", 1, 16'h2057, 8'h00, WORD_ONES, 32'h0000_0002);
		ln("#1:2057:00=3");
		ln("#5:2057:00=4");
		ln("6040:00 = 5");
		ln("6040:00= 5");
		ln(" 6040:00=5");
		ln("6040:0=6");
		ln("604:00=6");
		ln("6040=6");
		ln("3202:00.32=1");
		ln("20aB:0c=0Xa5", 1, 16'h20AB, 8'h0C, WORD_ONES, 32'h0000_00A5);
		ln("6040:00=0x");
		ln("1010:02=7\015", 1, 16'h1010, 8'h02, WORD_ONES, 32'h0000_0007);
		ln("4015:01=4294967295", 1, 16'h4015, 8'h01, WORD_ONES, WORD_ONES, "");
		boot(1'b0, 1'b0);
		// Random lines, slow storage, missing file.
		txt = "";
		exp_q.delete();
		sw = $urandom;
		repeat (40) rnd_line();
		boot(1'b1, 1'b1);
		// Empty file still leads to switches and program start.
		txt = "";
		exp_q.delete();
		sw = $urandom;
		boot(1'b0, 1'b1);
		tally_and_finish();
	end
endmodule : test_cfl_loader
